//--- rtl/pfa_regs.vh
// constants for the protective function a status image
`ifndef PFA_REGS_VH
`define PFA_REGS_VH

// ----------------------------------------------------------------------
// placement in the non-safe input telegram
// ----------------------------------------------------------------------
`define PFA_TEL_FIRST      5'h0E
`define PFA_TEL_LAST       5'h15
`define PFA_IMG_BYTES      4'h8
`define PFA_ADDR_W         5

// ----------------------------------------------------------------------
// module byte offsets
// ----------------------------------------------------------------------
`define PFA_OFS_OCCUPANCY  3'h0
`define PFA_OFS_INTERLOCK  3'h1
`define PFA_OFS_WARN_SEG   3'h2
`define PFA_OFS_PROT_SEG   3'h3
`define PFA_OFS_PAIR_12    3'h4
`define PFA_OFS_PAIR_3     3'h5
`define PFA_OFS_MATCH      3'h6
`define PFA_OFS_SPARE      3'h7

// ----------------------------------------------------------------------
// field positions, counted as bit index in the 64-bit image
// ----------------------------------------------------------------------
`define PFA_BIT_WARN_FREE  0
`define PFA_BIT_PROT_FREE  1
`define PFA_BIT_ACTIVE     4
`define PFA_BIT_WARN_RSI   8
`define PFA_BIT_PROT_RSI   9
`define PFA_BIT_WSEG1      16
`define PFA_BIT_WSEG2      17
`define PFA_BIT_PSEG1      24
`define PFA_BIT_PSEG2      25
`define PFA_LSB_PAIR1      32
`define PFA_LSB_PAIR2      36
`define PFA_LSB_PAIR3      40
`define PFA_BIT_MATCH1     48
`define PFA_BIT_MATCH2     49

// ----------------------------------------------------------------------
// pair number range and reset values
// ----------------------------------------------------------------------
`define PFA_PAIR_MIN       4'h1
`define PFA_PAIR_MAX       4'hA
`define PFA_PAIR_NONE      4'h0
`define PFA_IMG_RESET      64'h0000_0000_0000_0000
`define PFA_BYTE_ZERO      8'h00

`endif

//--- rtl/pfa_pair_check.v
// field pair number check and predefined pair comparison
`timescale 1ns/1ns
`include "pfa_regs.vh"

module pfa_pair_check
(
   input  wire [3:0] pair_in,
   input  wire [3:0] active_pair,
   input  wire [3:0] predef_pair,
   output wire [3:0] pair_out,
   output wire       pair_match
);

   // ----------------------------------------------------------------------
   // range check
   // ----------------------------------------------------------------------
   function pair_valid;
      input [3:0] num;
      begin
         pair_valid = (num >= `PFA_PAIR_MIN) && (num <= `PFA_PAIR_MAX);
      end
   endfunction

   // out-of-range numbers read as zero so the controller never sees 11..15
   assign pair_out   = pair_valid(pair_in) ? pair_in : `PFA_PAIR_NONE;
   // an unconfigured predefined pair never matches
   assign pair_match = pair_valid(predef_pair) && pair_valid(active_pair)
                       && (active_pair == predef_pair);

endmodule

//--- rtl/pfa_byte_select.v
// selects one byte of the status image by module byte index
`timescale 1ns/1ns

module pfa_byte_select
#(
   parameter NBYTES = 8,
   parameter IDX_W  = 3
)
(
   input  wire [NBYTES*8-1:0] image,
   input  wire [IDX_W-1:0]    index,
   output wire [7:0]          byte_out
);

   // indexed part-select keeps this a plain mux tree
   assign byte_out = image[index*8 +: 8];

endmodule

//--- rtl/pfa_status_image.v
// protective function a status image: builds, freezes and serves 8 bytes
//
// Contract
// - eight bytes at telegram bytes 14 to 21
// - byte0 bits0/1: warning/protective field, 1=free
// - byte0 bit4 set when function configured
// - byte1 bit0: warning field restart interlock active
// - byte1 bit1: protective field restart interlock active
// - bytes 2/3 bits0/1: segment occupancy, 1=free
// - byte4 bits0-3: first selected pair number
// - byte4 bits4-7: second pair; third unused
// - byte6 bits0/1: active equals predefined pair
`timescale 1ns/1ns
`include "pfa_regs.vh"

module pfa_status_image
#(
   parameter NBYTES = 8
)
(
   input  wire        ref_clk,
   input  wire        arst_n,
   // status from the scanner core, same clock domain
   input  wire        warn_field_free,
   input  wire        prot_field_free,
   input  wire        func_a_active,
   input  wire        warn_restart_interlock,
   input  wire        prot_restart_interlock,
   input  wire        warn_segment1_free,
   input  wire        warn_segment2_free,
   input  wire        prot_segment1_free,
   input  wire        prot_segment2_free,
   input  wire [3:0]  first_pair_sel,
   input  wire [3:0]  second_pair_sel,
   input  wire [3:0]  active_pair,
   input  wire [3:0]  predef_pair1,
   input  wire [3:0]  predef_pair2,
   // telegram cycle start from the fieldbus side, freezes the image while idle
   input  wire        cycle_start,
   // random byte read, addressed by telegram byte number
   input  wire        rd_en,
   input  wire [4:0]  rd_addr,
   output reg  [7:0]  rd_data,
   output reg         rd_hit,
   output reg         rd_valid,
   // byte stream of the frozen image towards the telegram builder
   output wire        tx_valid,
   input  wire        tx_ready,
   output reg  [7:0]  tx_data,
   output reg  [4:0]  tx_byte,
   output wire        tx_last,
   output wire        busy
);

   // ----------------------------------------------------------------------
   // local constants
   // ----------------------------------------------------------------------
   localparam IMG_W    = NBYTES * 8;
   localparam S_IDLE   = 2'b01;
   localparam S_SEND   = 2'b10;

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   reg  [IMG_W-1:0] live_image;
   reg  [IMG_W-1:0] next_image;
   reg  [IMG_W-1:0] snap_image;
   reg  [1:0]       state;
   reg  [1:0]       next_state;
   reg  [2:0]       tx_idx;
   reg  [2:0]       next_tx_idx;
   wire [3:0]       pair1_clean;
   wire [3:0]       pair2_clean;
   wire             match1;
   wire             match2;
   wire             unused_match;
   wire [3:0]       unused_pair;
   wire [7:0]       rd_byte;
   wire [7:0]       tx_byte_sel;
   wire [3:0]       rd_decode;
   wire             take_snap;
   wire             tx_fire;

   // ----------------------------------------------------------------------
   // address decode: telegram byte to module byte
   // ----------------------------------------------------------------------
   // returns {hit, module byte}; used by the read port only, the stream counts tx_idx itself
   function [3:0] tel_decode;
      input [4:0] addr;
      reg   [4:0] rel;
      begin
         rel = addr - `PFA_TEL_FIRST;
         if ((addr >= `PFA_TEL_FIRST) && (addr <= `PFA_TEL_LAST))
         begin
            tel_decode = {1'b1, rel[2:0]};
         end
         else
         begin
            tel_decode = 4'h0;
         end
      end
   endfunction

   // module byte back to telegram byte number
   function [4:0] tel_encode;
      input [2:0] idx;
      begin
         tel_encode = `PFA_TEL_FIRST + {2'b00, idx};
      end
   endfunction

   // ----------------------------------------------------------------------
   // pair number checks
   // ----------------------------------------------------------------------
   // first pair carries the match against predefined pair 1
   pfa_pair_check u_pair1
   (
      .pair_in     (first_pair_sel),
      .active_pair (active_pair),
      .predef_pair (predef_pair1),
      .pair_out    (pair1_clean),
      .pair_match  (match1)
   );

   // second pair carries the match against predefined pair 2
   pfa_pair_check u_pair2
   (
      .pair_in     (second_pair_sel),
      .active_pair (active_pair),
      .predef_pair (predef_pair2),
      .pair_out    (pair2_clean),
      .pair_match  (match2)
   );

   // the third pair number and the bit after match2 have no checker and are tied to zero
   assign unused_match = 1'b0;
   assign unused_pair  = `PFA_PAIR_NONE;

   // ----------------------------------------------------------------------
   // image assembly
   // ----------------------------------------------------------------------
   // start from all zero so every reserved bit stays low
   always @*
   begin
      next_image = `PFA_IMG_RESET;
      next_image[`PFA_BIT_WARN_FREE] = warn_field_free;
      next_image[`PFA_BIT_PROT_FREE] = prot_field_free;
      next_image[`PFA_BIT_ACTIVE]    = func_a_active;
      next_image[`PFA_BIT_WARN_RSI]  = warn_restart_interlock;
      next_image[`PFA_BIT_PROT_RSI]  = prot_restart_interlock;
      next_image[`PFA_BIT_WSEG1]     = warn_segment1_free;
      next_image[`PFA_BIT_WSEG2]     = warn_segment2_free;
      next_image[`PFA_BIT_PSEG1]     = prot_segment1_free;
      next_image[`PFA_BIT_PSEG2]     = prot_segment2_free;
      next_image[`PFA_LSB_PAIR1 +: 4] = pair1_clean;
      next_image[`PFA_LSB_PAIR2 +: 4] = pair2_clean;
      // third pair is not implemented and reads as zero
      next_image[`PFA_LSB_PAIR3 +: 4] = unused_pair;
      next_image[`PFA_BIT_MATCH1]    = match1;
      next_image[`PFA_BIT_MATCH2]    = match2;
      next_image[`PFA_BIT_MATCH2 + 1] = unused_match;
   end

   // live image follows the core one cycle late; reset shows all occupied
   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         live_image <= `PFA_IMG_RESET;
      end
      else
      begin
         live_image <= next_image;
      end
   end

   // ----------------------------------------------------------------------
   // snapshot per byte
   // ----------------------------------------------------------------------
   // the frozen copy keeps all eight bytes from one instant, so a
   // controller never sees a field from one scan and its segment from another
   assign take_snap = cycle_start && (state == S_IDLE);

   genvar gi;
   generate
      for (gi = 0; gi < NBYTES; gi = gi + 1)
      begin : g_snap
         always @(posedge ref_clk or negedge arst_n)
         begin
            if (!arst_n)
            begin
               snap_image[gi*8 +: 8] <= `PFA_BYTE_ZERO;
            end
            else if (take_snap)
            begin
               snap_image[gi*8 +: 8] <= live_image[gi*8 +: 8];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // random read port
   // ----------------------------------------------------------------------
   assign rd_decode = tel_decode(rd_addr);

   pfa_byte_select #(.NBYTES(NBYTES), .IDX_W(3)) u_rd_sel
   (
      .image    (snap_image),
      .index    (rd_decode[2:0]),
      .byte_out (rd_byte)
   );

   // answer one cycle after the request; outside 14..21 reads zero
   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rd_data  <= `PFA_BYTE_ZERO;
         rd_hit   <= 1'b0;
         rd_valid <= 1'b0;
      end
      else
      begin
         rd_valid <= rd_en;
         if (rd_en)
         begin
            rd_hit  <= rd_decode[3];
            rd_data <= rd_decode[3] ? rd_byte : `PFA_BYTE_ZERO;
         end
      end
   end

   // ----------------------------------------------------------------------
   // stream sequencer
   // ----------------------------------------------------------------------
   assign tx_valid = (state == S_SEND);
   assign tx_fire  = tx_valid && tx_ready;
   assign tx_last  = tx_valid && (tx_idx == `PFA_OFS_SPARE);
   assign busy     = (state == S_SEND);

   // a start seen while sending is ignored so the frame stays consistent
   always @*
   begin
      next_state  = state;
      next_tx_idx = tx_idx;
      case (state)
         S_IDLE:
         begin
            if (cycle_start)
            begin
               next_state  = S_SEND;
               next_tx_idx = `PFA_OFS_OCCUPANCY;
            end
         end
         S_SEND:
         begin
            if (tx_fire)
            begin
               if (tx_idx == `PFA_OFS_SPARE)
               begin
                  next_state = S_IDLE;
               end
               else
               begin
                  next_tx_idx = tx_idx + 3'd1;
               end
            end
         end
         default:
         begin
            next_state  = S_IDLE;
            next_tx_idx = `PFA_OFS_OCCUPANCY;
         end
      endcase
   end

   // state and byte counter
   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state  <= S_IDLE;
         tx_idx <= `PFA_OFS_OCCUPANCY;
      end
      else
      begin
         state  <= next_state;
         tx_idx <= next_tx_idx;
      end
   end

   // ----------------------------------------------------------------------
   // stream data
   // ----------------------------------------------------------------------
   // selection uses the next index so the data register lines up with it
   pfa_byte_select #(.NBYTES(NBYTES), .IDX_W(3)) u_tx_sel
   (
      .image    (take_snap ? live_image : snap_image),
      .index    (next_tx_idx),
      .byte_out (tx_byte_sel)
   );

   // data and byte number come from flip-flops, updated with the index
   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tx_data <= `PFA_BYTE_ZERO;
         tx_byte <= `PFA_TEL_FIRST;
      end
      else
      begin
         tx_data <= tx_byte_sel;
         tx_byte <= tel_encode(next_tx_idx);
      end
   end

endmodule

//--- tb/pfa_status_image_checker.sv
// assertions on the status image ports
`timescale 1ns/1ns
module pfa_status_image_checker
(
   input wire       ref_clk,
   input wire       arst_n,
   input wire       rd_en,
   input wire [4:0] rd_addr,
   input wire [7:0] rd_data,
   input wire       rd_hit,
   input wire       rd_valid,
   input wire       tx_valid,
   input wire       tx_ready,
   input wire [7:0] tx_data,
   input wire [4:0] tx_byte,
   input wire       tx_last,
   input wire       busy
);
   // ------------------------------------------------------------
   // one clock domain, so one default clocking and disable
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   // read port answers exactly one cycle later, telegram window only
   chk_read_answer: assert property (rd_en |=> rd_valid)
      else $error("read not answered after one cycle");
   chk_read_hit: assert property (rd_en |=>
      rd_hit == ($past(rd_addr) >= 5'h0E && $past(rd_addr) <= 5'h15))
      else $error("read hit does not match address window");
   chk_miss_zero: assert property (rd_valid && !rd_hit |-> rd_data == 8'h00)
      else $error("refused read returned data");
   // stream: bytes 14 to 21 in order, held while stalled
   chk_tx_range: assert property (tx_valid |-> tx_byte inside {[5'h0E:5'h15]})
      else $error("stream byte number outside window");
   chk_last_flag: assert property (tx_last == (tx_valid && tx_byte == 5'h15))
      else $error("last flag not on final byte");
   chk_stall_hold: assert property (tx_valid && !tx_ready |=>
      tx_valid && $stable(tx_data) && $stable(tx_byte))
      else $error("stream byte changed while stalled");
   chk_byte_order: assert property (tx_valid && tx_ready && !tx_last |=>
      tx_valid && tx_byte == $past(tx_byte) + 5'h01)
      else $error("stream bytes out of order");
   chk_frame_end: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
      else $error("stream did not end after final byte");
   chk_busy_frame: assert property (busy == tx_valid)
      else $error("busy differs from stream valid");
   chk_spare_zero: assert property (tx_valid && (tx_byte == 5'h13 || tx_byte == 5'h15)
      |-> tx_data == 8'h00)
      else $error("spare byte not zero");
   chk_byte0_resv: assert property (tx_valid && tx_byte == 5'h0E
      |-> (tx_data & 8'hEC) == 8'h00)
      else $error("reserved bits of byte 0 set");

   // main scenarios reached
   cover property (rd_valid && rd_hit);
   cover property (tx_valid && !tx_ready);
   cover property (tx_last && tx_ready);
endmodule

bind pfa_status_image pfa_status_image_checker pfa_status_image_checker_inst
(
   .ref_clk, .arst_n, .rd_en, .rd_addr, .rd_data, .rd_hit, .rd_valid,
   .tx_valid, .tx_ready, .tx_data, .tx_byte, .tx_last, .busy
);

//--- tb/pfa_io_ctrl_model.sv
// behavioural fieldbus controller collecting the streamed image
`timescale 1ns/1ns
module pfa_io_ctrl_model
(
   input  wire        ref_clk,
   input  wire        arst_n,
   input  wire        stall,
   input  wire        tx_valid,
   input  wire [7:0]  tx_data,
   input  wire [4:0]  tx_byte,
   input  wire        tx_last,
   output reg         tx_ready,
   output reg  [63:0] rx_image,
   output reg         rx_done
);
   // ready toggles while stalling so every byte after the first meets a held cycle
   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tx_ready <= 1'b0;
         rx_image <= 64'h0000_0000_0000_0000;
         rx_done  <= 1'b0;
      end
      else
      begin
         tx_ready <= stall ? ~tx_ready : 1'b1;
         if (tx_valid && tx_ready)
            rx_image[(tx_byte - 5'h0E) * 8 +: 8] <= tx_data;
         if (tx_valid)
            rx_done <= tx_ready && tx_last; // stays set until a new frame
      end
   end
endmodule

//--- tb/test_pfa_status_image.sv
// self-checking bench for the status image block
`timescale 1ns/1ns
module test_pfa_status_image;
   reg        ref_clk, arst_n, cs, rd_en, stall;
   reg [4:0]  rd_addr;
   reg [8:0]  st;
   reg [3:0]  f1, f2, ap, d1, d2;
   reg [63:0] exp_img;
   wire [7:0] rd_data, tx_data;
   wire [4:0] tx_byte;
   wire       rd_hit, rd_valid, tx_valid, tx_ready, tx_last, rx_done;
   wire [63:0] rx_image;
   integer    failures, compares, cyc, i;

   pfa_status_image pfa_status_image_inst
   (
      .ref_clk(ref_clk), .arst_n(arst_n),
      .warn_field_free(st[8]), .prot_field_free(st[7]), .func_a_active(st[6]),
      .warn_restart_interlock(st[5]), .prot_restart_interlock(st[4]),
      .warn_segment1_free(st[3]), .warn_segment2_free(st[2]),
      .prot_segment1_free(st[1]), .prot_segment2_free(st[0]),
      .first_pair_sel(f1), .second_pair_sel(f2), .active_pair(ap),
      .predef_pair1(d1), .predef_pair2(d2), .cycle_start(cs),
      .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_hit(rd_hit),
      .rd_valid(rd_valid), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_data(tx_data), .tx_byte(tx_byte), .tx_last(tx_last), .busy()
   );
   pfa_io_ctrl_model pfa_io_ctrl_model_inst
   (
      .ref_clk(ref_clk), .arst_n(arst_n), .stall(stall), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_byte(tx_byte), .tx_last(tx_last),
      .tx_ready(tx_ready), .rx_image(rx_image), .rx_done(rx_done)
   );

   // ------------------------------------------------------------
   // clock, hang guard and shared tasks
   // ------------------------------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // no run should need more than a few hundred cycles
   always @(posedge ref_clk)
   begin
      cyc = cyc + 1;
      if (cyc == 3000)
      begin
         failures = failures + 1;
         report_and_stop;
      end
   end

   task check(input string name, input [63:0] e, input [63:0] g);
      begin
         compares = compares + 1;
         if (g !== e)
         begin
            failures = failures + 1;
            $display("ERROR %s expected %h seen %h", name, e, g);
         end
      end
   endtask

   // drive status, let it settle into the live image, work out the image
   task set_st(input [8:0] b, input [3:0] a1, a2, a, p1, p2);
      reg m1, m2;
      reg [3:0] c1, c2;
      begin
         @(posedge ref_clk);
         st <= b;
         f1 <= a1;
         f2 <= a2;
         ap <= a;
         d1 <= p1;
         d2 <= p2;
         repeat (3) @(posedge ref_clk);
         m1 = (a >= 4'h1 && a <= 4'hA && a == p1);
         m2 = (a >= 4'h1 && a <= 4'hA && a == p2);
         // pair numbers outside 1..10 are reported as zero
         c1 = (a1 >= 4'h1 && a1 <= 4'hA) ? a1 : 4'h0;
         c2 = (a2 >= 4'h1 && a2 <= 4'hA) ? a2 : 4'h0;
         exp_img = {8'h00, 6'h00, m2, m1, 8'h00, c2, c1, 6'h00, b[0], b[1],
                    6'h00, b[2], b[3], 6'h00, b[4], b[5], 3'h0, b[6], 2'h0, b[7], b[8]};
      end
   endtask

   task kick;
      begin
         @(posedge ref_clk);
         cs <= 1'b1;
         @(posedge ref_clk);
         cs <= 1'b0;
         repeat (2) @(posedge ref_clk);
      end
   endtask

   task wait_done;
      integer n;
      begin
         n = 0;
         while (rx_done !== 1'b1 && n < 300)
         begin
            @(posedge ref_clk);
            n = n + 1;
         end
         check("frame completion", 64'h1, {63'h0, rx_done});
      end
   endtask

   task rd(input [4:0] a, input eh, input [7:0] ed);
      begin
         @(posedge ref_clk);
         rd_en <= 1'b1;
         rd_addr <= a;
         @(posedge ref_clk);
         rd_en <= 1'b0;
         @(negedge ref_clk);
         check("read answer", {62'h0, 1'b1, eh, ed}, {62'h0, rd_valid, rd_hit, rd_data});
      end
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // before any snapshot byte 14 reads zero and byte 13 is refused
   task t_reset;
      begin
         rd(5'h0E, 1'b1, 8'h00);
         rd(5'h0D, 1'b0, 8'h00);
         $display("t_reset done");
      end
   endtask

   // stalled stream; a second start while busy must not resnapshot
   task t_stall;
      reg [63:0] e;
      begin
         stall <= 1'b1;
         set_st(9'h155, 4'h3, 4'hA, 4'h3, 4'h3, 4'h8);
         e = exp_img;
         kick;
         set_st(9'h0AA, 4'h5, 4'h6, 4'h8, 4'h1, 4'h8);
         kick;
         wait_done;
         check("stalled image", e, rx_image);
         stall <= 1'b0;
         exp_img = e;
         $display("t_stall done");
      end
   endtask

   // every telegram byte read at random, plus the upper neighbour 0x16 refused
   task t_reads;
      begin
         for (i = 0; i < 8; i = i + 1)
            rd(5'h0E + i[4:0], 1'b1, exp_img[i*8 +: 8]);
         rd(5'h16, 1'b0, 8'h00);
         $display("t_reads done");
      end
   endtask

   // walk a single status bit and vary pair numbers and matches
   task t_walk;
      begin
         for (i = 0; i < 9; i = i + 1)
         begin
            set_st(9'h001 << i, i[3:0] + 4'h1, 4'hA - i[3:0], i[3:0] + 4'h1,
                   i[0] ? i[3:0] + 4'h1 : 4'h0, (i % 3 == 0) ? i[3:0] + 4'h1 : 4'h2);
            kick;
            wait_done;
            check("walk image", exp_img, rx_image);
         end
         $display("t_walk done");
      end
   endtask

   // out-of-range pair numbers read zero and never match
   task t_range;
      begin
         set_st(9'h1FF, 4'hF, 4'h0, 4'h5, 4'h5, 4'hC);
         kick;
         wait_done;
         check("range image a", exp_img, rx_image);
         set_st(9'h1FF, 4'hB, 4'hE, 4'hB, 4'hB, 4'hB);
         kick;
         wait_done;
         check("range image b", exp_img, rx_image);
         $display("t_range done");
      end
   endtask

   task report_and_stop;
      begin
         $display("compares %0d failures %0d", compares, failures);
         if (failures == 0 && compares > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      failures = 0;
      compares = 0;
      cyc = 0;
      arst_n = 1'b0;
      cs = 1'b0;
      rd_en = 1'b0;
      rd_addr = 5'h00;
      stall = 1'b0;
      st = 9'h000;
      f1 = 4'h0;
      f2 = 4'h0;
      ap = 4'h0;
      d1 = 4'h0;
      d2 = 4'h0;
      repeat (6) @(posedge ref_clk);
      arst_n <= 1'b1;
      t_reset;
      t_stall;
      t_reads;
      t_walk;
      t_range;
      report_and_stop;
   end
endmodule
